// ===== check_map.svh
//////////////////////////////////////////////////////////////////////
// Behaviour
// - Bits 0..2 choose one of five codes
// - Mode write other than a counted step presets shift counter 0 or 2
// - Bit 3 picks byte or word loading
// - Bit 6 gives cycle mode; step ignored
// - Clear bit zeroes check, sets done
// - Done flag readable, ignores writes
// - Data write loads word, clears done unless a finish coincides
// - Shifting starts after write ends, stops
// - Finish sets done, back to load
// - Longitudinal codes: per-bit modulo-2 sum
// - Cyclic codes: keep division remainder only
// - Sixteen-bit cyclic: 8-bit chars, 16 bits
// - Twelve-bit cyclic: 6-bit chars, 12 bits
// - Telecom cyclic: 8-bit chars, 16 bits
// - Eight-bit longitudinal: 8-bit XOR sum
// - Sixteen-bit longitudinal: 16-bit XOR sum
// - Low check byte is sent first
// - Step mode: load runs no shifting
// - Each step write gives one shift while a load is pending
// - Word mode counter advances every two shifts
// - No interrupt; done flag is polled
//////////////////////////////////////////////////////////////////////
`ifndef CHECK_MAP_SVH
`define CHECK_MAP_SVH

// Register byte offsets
`define CSR_OFS 3'h0
`define CHK_OFS 3'h2
`define DAT_OFS 3'h4

// Control/status bit positions
`define B_WIDE 0
`define B_LRC 1
`define B_VAR 2
`define B_WORD 3
`define B_CLR 4
`define B_STEP 5
`define B_CYC 6
`define B_DONE 7
`define B_QBIT 8

// Shift counter presets and terminal value
`define CNT_PRE_8 3'h0
`define CNT_PRE_6 3'h2
`define CNT_LAST 3'h7

// Reflected generator patterns, fed from the low end
`define POLY_CRC16 16'ha001
`define POLY_CCITT 16'h8408
`define POLY_CRC12 16'h0f01
`define POLY_LRC16 16'h8000
`define POLY_LRC8 16'h0080

// Reset values
`define CHK_RST 16'h0000
`define DAT_RST 16'h0000
`define DONE_RST 1'b1
`define CNT_RST 3'h0

`endif

// ===== check_pkg.sv
`default_nettype none
package check_pkg;
   // Shift sequencer states, one-hot
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_wait = 3'b010,
      st_run = 3'b100
   } seq_state_t;
endpackage
`default_nettype wire

// ===== shift_step.sv
`timescale 1ns/10ps
`default_nettype none
// One serial divide step of the check register
module shift_step #(
   parameter int W = 16
) (
   input wire logic [W-1:0] chk,
   input wire logic data_bit,
   input wire logic [W-1:0] poly,
   output logic [W-1:0] chk_nxt,
   output logic quotient_bit
);
   // Feedback bit is the quotient bit of this step
   assign quotient_bit = chk[0] ^ data_bit;

   // Shift toward the low end, fold in generator on a one
   // Longitudinal patterns hold one bit, so this is a rotate-XOR
   assign chk_nxt = {1'b0, chk[W-1:1]} ^ ({W{quotient_bit}} & poly);
endmodule // shift_step
`default_nettype wire

// ===== block_check_accumulator.sv
`timescale 1ns/10ps
`default_nettype none
`include "check_map.svh"
module block_check_accumulator
   import check_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic bus_sel,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [2:0] bus_addr,
   input wire logic [W-1:0] bus_wdata,
   output logic [W-1:0] bus_rdata
);

   //////////////////////////////////////////////////////////////////
   // Declarations

   // Mode bits held from the last control write
   logic wide_check_select_r;
   logic lrc_select_r;
   logic crc_variant_r;
   logic word_load_select_r;
   logic cycle_mode_select_r;

   // Completion flag, readback only; loads do not depend on it
   logic done_r;
   // Accumulated check value
   logic [W-1:0] chk_r;
   // Data register, shifts out from bit 0
   logic [W-1:0] dat_r;
   // Modulo-8 shift counter and word-mode halver
   logic [2:0] cnt_r;
   logic half_r;
   // Sequencer state
   seq_state_t state_r;
   seq_state_t state_nxt;
   // Read data holding register
   logic [W-1:0] rdata_r;

   // Bus decodes
   logic wr_csr;
   logic wr_dat;
   logic rd_any;
   // Control pulses from a control write
   logic clr_pls;
   logic step_pls;
   // Shift and counter events
   logic shift_en;
   logic adv;
   logic last;
   // Generator pattern for the current code
   logic [W-1:0] poly;
   // Step results
   logic [W-1:0] chk_nxt;
   logic quotient_bit;
   // Counter presets
   logic [2:0] pre_wr;
   logic [2:0] pre_reg;
   // Readback view of the control/status word
   logic [W-1:0] csr_view;

   //////////////////////////////////////////////////////////////////
   // Bus decode

   // Control write
   assign wr_csr = bus_sel & bus_wr & (bus_addr == `CSR_OFS);
   // Data write, a level for the whole access
   assign wr_dat = bus_sel & bus_wr & (bus_addr == `DAT_OFS);
   // Any read
   assign rd_any = bus_sel & bus_rd;

   // Clear request
   assign clr_pls = wr_csr & bus_wdata[`B_CLR];
   // Step only counts with cycle mode off in the same write
   assign step_pls = wr_csr & bus_wdata[`B_STEP] & ~bus_wdata[`B_CYC]
                     & (state_r == st_wait);

   //////////////////////////////////////////////////////////////////
   // Code selection

   // Pattern from wide, longitudinal and variant bits
   always_comb begin
      if (lrc_select_r) begin
         // Longitudinal: width from the wide bit
         poly = wide_check_select_r ? `POLY_LRC16 : `POLY_LRC8;
      end else if (wide_check_select_r) begin
         // Sixteen-bit cyclic, standard or telecom
         poly = crc_variant_r ? `POLY_CCITT : `POLY_CRC16;
      end else begin
         // Twelve-bit cyclic
         poly = `POLY_CRC12;
      end
   end

   // Twelve-bit code takes six bits per character
   assign pre_wr = (~bus_wdata[`B_WIDE] & ~bus_wdata[`B_LRC]) ?
                   `CNT_PRE_6 : `CNT_PRE_8;
   assign pre_reg = (~wide_check_select_r & ~lrc_select_r) ?
                    `CNT_PRE_6 : `CNT_PRE_8;

   //////////////////////////////////////////////////////////////////
   // Shift datapath

   shift_step #(
      .W(W)
   ) u_step (
      .chk(chk_r),
      .data_bit(dat_r[0]),
      .poly(poly),
      .chk_nxt(chk_nxt),
      .quotient_bit(quotient_bit)
   );

   // One shift per cycle when running, or one per step write
   assign shift_en = (state_r == st_run) | step_pls;
   // Word mode advances the counter on every second shift
   assign adv = shift_en & (~word_load_select_r | half_r);
   // Counter wrap ends the character
   assign last = adv & (cnt_r == `CNT_LAST);

   //////////////////////////////////////////////////////////////////
   // Mode register

   // Mode bits change only on a control write
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wide_check_select_r <= 1'b0;
         lrc_select_r <= 1'b0;
         crc_variant_r <= 1'b0;
         word_load_select_r <= 1'b0;
         cycle_mode_select_r <= 1'b0;
      end else if (wr_csr) begin
         wide_check_select_r <= bus_wdata[`B_WIDE];
         lrc_select_r <= bus_wdata[`B_LRC];
         crc_variant_r <= bus_wdata[`B_VAR];
         word_load_select_r <= bus_wdata[`B_WORD];
         cycle_mode_select_r <= bus_wdata[`B_CYC];
      end
   end

   //////////////////////////////////////////////////////////////////
   // Sequencer

   // Next state; a new data load always restarts the character
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_idle: begin
            // Waiting for a character
            if (wr_dat) begin
               state_nxt = st_wait;
            end
         end
         st_wait: begin
            // Loaded; hold while the write lasts
            if (clr_pls || last) begin
               state_nxt = st_idle;
            end else if (!wr_dat && cycle_mode_select_r) begin
               state_nxt = st_run;
            end
            // Step mode stays here; only steps shift
         end
         st_run: begin
            // Free-running shifts until the counter wraps
            if (wr_dat) begin
               state_nxt = st_wait;
            end else if (clr_pls || last) begin
               state_nxt = st_idle;
            end
         end
         default: begin
            state_nxt = st_idle;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_r <= st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Done flag

   // Set wins over the load clear; bus writes never store it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         done_r <= `DONE_RST;
      end else if (clr_pls || last) begin
         done_r <= 1'b1;
      end else if (wr_dat) begin
         done_r <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Shift counter

   // Preset on mode write other than a counted step, and on every load
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_r <= `CNT_RST;
         half_r <= 1'b0;
      end else if (wr_csr && !step_pls) begin
         cnt_r <= pre_wr;
         half_r <= 1'b0;
      end else if (wr_dat) begin
         cnt_r <= pre_reg;
         half_r <= 1'b0;
      end else if (shift_en) begin
         // Halver only toggles in word mode
         half_r <= word_load_select_r & ~half_r;
         if (adv) begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // Check register

   // Only clear and shifts touch it; it has no write path
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         chk_r <= `CHK_RST;
      end else if (clr_pls) begin
         chk_r <= `CHK_RST;
      end else if (shift_en) begin
         chk_r <= chk_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Data register

   // Parallel load, then shift out from the low end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dat_r <= `DAT_RST;
      end else if (wr_dat) begin
         // Byte mode keeps only the low character
         if (word_load_select_r) begin
            dat_r <= bus_wdata;
         end else begin
            dat_r <= {8'h00, bus_wdata[7:0]};
         end
      end else if (shift_en) begin
         dat_r <= {1'b0, dat_r[W-1:1]};
      end
   end

   //////////////////////////////////////////////////////////////////
   // Readback

   // Status view; clear and step read as zero
   always_comb begin
      csr_view = '0;
      csr_view[`B_WIDE] = wide_check_select_r;
      csr_view[`B_LRC] = lrc_select_r;
      csr_view[`B_VAR] = crc_variant_r;
      csr_view[`B_WORD] = word_load_select_r;
      csr_view[`B_CYC] = cycle_mode_select_r;
      csr_view[`B_DONE] = done_r;
      csr_view[`B_QBIT] = quotient_bit;
   end

   // Registered read, one cycle later, held until the next read
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata_r <= '0;
      end else if (rd_any) begin
         case (bus_addr)
            `CSR_OFS: rdata_r <= csr_view;
            // Low byte is the first to send
            `CHK_OFS: rdata_r <= chk_r;
            `DAT_OFS: rdata_r <= dat_r;
            default: rdata_r <= '0;
         endcase
      end
   end

   assign bus_rdata = rdata_r;

   //////////////////////////////////////////////////////////////////
   // Checks

   // Clear zeroes the check and raises done
   a_clear_zeroes_check: assert property (
      @(posedge clk) disable iff (!rst_b)
      clr_pls |=> (chk_r == '0) && done_r)
      else $error("clear did not zero check or set done");

   // Word-mode load drops done and captures the whole data word
   a_load_drops_done: assert property (
      @(posedge clk) disable iff (!rst_b)
      (wr_dat && word_load_select_r) |=>
         !done_r && (dat_r == $past(bus_wdata)))
      else $error("data load not taken");

   // Nothing runs while the write is still on the bus
   a_no_early_shift: assert property (
      @(posedge clk) disable iff (!rst_b)
      wr_dat |=> state_r != st_run)
      else $error("shifting began during the write");

   // Byte character: eight shifts then done
   a_byte_eight_shifts: assert property (
      @(posedge clk) disable iff (!rst_b)
      (state_r == st_wait && !wr_dat && !wr_csr && cycle_mode_select_r
       && !word_load_select_r && cnt_r == `CNT_PRE_8)
      |=> (state_r == st_run)[*8] ##1 (done_r && state_r == st_idle))
      else $error("byte character length wrong");

   // Word character: sixteen shifts then done
   a_word_sixteen: assert property (
      @(posedge clk) disable iff (!rst_b)
      (state_r == st_wait && !wr_dat && !wr_csr && cycle_mode_select_r
       && word_load_select_r && cnt_r == `CNT_PRE_8)
      |=> ##15 (state_r == st_run) ##1 done_r)
      else $error("word character length wrong");

   // Step mode never free-runs
   a_step_no_run: assert property (
      @(posedge clk) disable iff (!rst_b)
      (state_r == st_wait && !cycle_mode_select_r && !wr_csr)
      |=> state_r != st_run)
      else $error("step mode ran on its own");

   // A step moves both registers exactly once
   a_step_one_shift: assert property (
      @(posedge clk) disable iff (!rst_b)
      (step_pls && !clr_pls) |=> (chk_r == $past(chk_nxt))
         && (dat_r == ($past(dat_r) >> 1)))
      else $error("step did not give one shift");

   // Counter preset follows the chosen code
   a_counter_preset: assert property (
      @(posedge clk) disable iff (!rst_b)
      (wr_csr && !step_pls) |=> cnt_r == ((lrc_select_r
         || wide_check_select_r) ? `CNT_PRE_8 : `CNT_PRE_6))
      else $error("shift counter preset wrong");

   // Idle done flag survives plain control writes
   a_done_holds: assert property (
      @(posedge clk) disable iff (!rst_b)
      (wr_csr && state_r == st_idle && done_r) |=> done_r)
      else $error("done flag changed by a write");

endmodule // block_check_accumulator
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor side: issues one bus access per call, in call order
module host_model (
   input wire logic clk,
   output logic bus_sel,
   output logic bus_wr,
   output logic bus_rd,
   output logic [2:0] bus_addr,
   output logic [15:0] bus_wdata
);
   // Idle bus at time zero
   initial begin
      bus_sel = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 3'h6;
      bus_wdata = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////
   // One-cycle access; released lines carry inverted values so stale
   // address or data can never pass for a live request
   task automatic access(input logic [2:0] a, input logic [15:0] d, input logic w);
      @(posedge clk);
      bus_sel <= 1'b1;
      bus_wr <= w;
      bus_rd <= ~w;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_sel <= 1'b0;
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
   endtask
endmodule // host_model
`default_nettype wire

// ===== block_check_accumulator_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "check_map.svh"
module block_check_accumulator_bench;
   typedef struct packed {logic [15:0] e; logic [15:0] m;} note_t;
   logic clk = 1'b0; // System clock
   logic rst_b = 1'b0; // Held low at start
   logic bus_sel, bus_wr, bus_rd;
   logic [2:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, d, chk_m;
   logic rd_seen = 1'b0; // A read was taken last edge
   note_t q[$]; // Expected read results, oldest first
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [15:0] ctrl[6] = '{16'h0051, 16'h0055, 16'h0050, 16'h0052, 16'h005b, 16'h0059};
   logic [15:0] poly[6] = '{`POLY_CRC16, `POLY_CCITT, `POLY_CRC12, 16'h0000, 16'h0000, `POLY_CRC16};
   int nsh[6] = '{8, 8, 6, 8, 16, 16};

   always #2 clk = ~clk;

   host_model host_model_i (.clk(clk), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata));
   block_check_accumulator block_check_accumulator_i (.clk(clk), .rst_b(rst_b),
      .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   ////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Serial divide, data bit 0 first; only the remainder is kept
   function automatic logic [15:0] step_ref(logic [15:0] c, logic [15:0] x, logic [15:0] p,
      int n);
      for (int i = 0; i < n; i++) begin
         c = (c >> 1) ^ ((c[0] ^ x[i]) ? p : 16'h0000);
      end
      return c;
   endfunction

   // Note the expectation, then issue the read
   task automatic rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
      q.push_back('{e & m, m});
      host_model_i.access(a, 16'h0000, 1'b0);
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] x);
      host_model_i.access(a, x, 1'b1);
   endtask

   // Watcher: read data is valid one cycle after the read edge
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         $display("[FAIL] %0t run did not finish", $time);
         test_done();
      end else begin
         if (rd_seen) begin
            total_checks++;
            if (q.size() == 0 || (bus_rdata & q[0].m) !== q[0].e) begin
               err_total++;
               $display("[FAIL] %0t read data %h unexpected", $time, bus_rdata);
            end
            if (q.size() > 0) void'(q.pop_front());
         end
         rd_seen = bus_sel & bus_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hdddb));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd(`CSR_OFS, 16'h0080, 16'hffff);
      rd(`CHK_OFS, 16'h0000, 16'hffff);
      rd(3'h6, 16'h0000, 16'hffff);
      // Cycle mode, every code; clear, then three random characters
      for (int k = 0; k < 6; k++) begin
         wr(`CSR_OFS, ctrl[k]);
         rd(`CSR_OFS, (ctrl[k] & 16'h004f) | 16'h0080, 16'h00ff);
         rd(`CHK_OFS, 16'h0000, 16'hffff);
         chk_m = 16'h0000;
         for (int j = 0; j < 3; j++) begin
            d = 16'($urandom()); // Word mode: earlier character in low byte
            wr(`DAT_OFS, d);
            if (j == 0) rd(`CSR_OFS, 16'h0000, 16'h0080);
            repeat (20) @(posedge clk);
            if (k == 3 || k == 4)
               chk_m = chk_m ^ (d & 16'((32'h1 << nsh[k]) - 1)); // XOR sum only
            else
               chk_m = step_ref(chk_m, d, poly[k], nsh[k]);
            rd(`CSR_OFS, 16'h0080, 16'h0080);
         end
         repeat (2) rd(`CHK_OFS, chk_m, 16'hffff);
      end
      // Refused writes: check register, unmapped place, done bit
      wr(`CHK_OFS, ~chk_m);
      wr(3'h6, 16'hffff);
      wr(`CSR_OFS, 16'h0041);
      rd(3'h6, 16'h0000, 16'hffff);
      rd(`CSR_OFS, 16'h00c1, 16'h00ff);
      rd(`CHK_OFS, chk_m, 16'hffff);
      // Step mode: a load alone must not shift
      wr(`CSR_OFS, 16'h0011);
      d = 16'($urandom());
      wr(`DAT_OFS, d);
      repeat (20) @(posedge clk);
      rd(`CSR_OFS, {7'h00, d[0], 8'h01}, 16'h01ff);
      rd(`CHK_OFS, 16'h0000, 16'hffff);
      rd(`DAT_OFS, {8'h00, d[7:0]}, 16'hffff);
      chk_m = 16'h0000;
      for (int i = 0; i < 8; i++) begin
         wr(`CSR_OFS, 16'h0021);
         chk_m = step_ref(chk_m, d >> i, `POLY_CRC16, 1);
         rd(`CHK_OFS, chk_m, 16'hffff);
         rd(`CSR_OFS, (i == 7) ? 16'h0080 : 16'h0000, 16'h0080);
      end
      repeat (4) @(posedge clk);
      test_done();
   end
endmodule // block_check_accumulator_bench
`default_nettype wire
